// *** sim/host_model.sv ***
// Purpose: remote host driving the command bus
// Assumes: answer stands in the cycle after the taking edge
// Notes:   idle code and data fields show the inverse of the last command; channel keeps its value
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        clk_sys,
  output var  logic        cmd_valid,
  output var  logic [3:0]  cmd_code,
  output var  logic        cmd_chan,
  output var  logic [31:0] cmd_data,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 4'h0;
    cmd_chan  = 1'b0;
    cmd_data  = 32'h00000000;
  end
  // ----
  // one command, held until the taking edge
  // ----
  task automatic send(input logic [3:0] c, logic ch, logic [31:0] d,
                      output logic rv, logic [31:0] rd);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_chan  <= ch;
    cmd_data  <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
    cmd_data  <= ~d;
    #1;
    rv = resp_valid;
    rd = resp_data;
  endtask
endmodule // host_model
`default_nettype wire

// *** sim/level_limit_error_queue_burst_test.sv ***
// Purpose: self-checking bench of the command block
// Assumes: status select 0..7 in register table order
// Notes:   queue depth kept at 8
`timescale 1ns/100ps
`default_nettype none
module level_limit_error_queue_burst_test;
  localparam QD = 8;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        panel_check_off = 1'b0;
  logic        arm = 1'b0;
  logic        period_tick = 1'b0;
  logic [15:0] operation_condition = 16'h0000, questionable_condition = 16'h0000;
  logic        cmd_valid, cmd_chan, resp_valid, rv;
  logic [3:0]  cmd_code;
  logic [31:0] cmd_data, resp_data, level_high_bus, level_low_bus, rd;
  logic [1:0]  output_enabled;
  logic        level_limit_switch, error_check_switch, bit_pattern_operation, double_pulse_select;
  logic [16:0] period_count_per_arm;
  logic        burst_busy, period_strobe, pulse_strobe, second_pulse_strobe, bit_strobe;
  logic [13:0] bit_index;
  int          num_errors = 0, n_compared = 0, n_pulse = 0, n_second = 0, n_bit = 0, i;
  logic [31:0] stat_exp [0:7] = '{32'h0, 32'h7FFF, 32'h0, 32'h0, 32'h7FFF, 32'h0, 32'h0, 32'h0};
  always #12.5 clk_sys = ~clk_sys;
  host_model i_host_model (.clk_sys, .cmd_valid, .cmd_code, .cmd_chan, .cmd_data, .resp_valid, .resp_data);
  level_limit_error_queue_burst #(.QUEUE_DEPTH(QD), .QUEUE_AW(3)) i_level_limit_error_queue_burst (
    .clk_sys, .reset_n, .cmd_valid, .cmd_code, .cmd_chan, .cmd_data, .resp_valid, .resp_data,
    .panel_check_off, .operation_condition, .questionable_condition, .arm, .period_tick,
    .level_high_bus, .level_low_bus, .output_enabled, .level_limit_switch, .error_check_switch,
    .bit_pattern_operation, .double_pulse_select, .period_count_per_arm, .burst_busy, .period_strobe,
    .pulse_strobe, .second_pulse_strobe, .bit_strobe, .bit_index);
  always @(posedge clk_sys) begin
    n_pulse  <= n_pulse + (pulse_strobe === 1'b1);
    n_second <= n_second + (second_pulse_strobe === 1'b1);
    n_bit    <= n_bit + (bit_strobe === 1'b1);
  end
  // ----
  // helpers
  // ----
  task automatic chk(input string nm, logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  task automatic cmd(input logic [3:0] c, logic ch, logic [31:0] d);
    i_host_model.send(c, ch, d, rv, rd);
  endtask
  task automatic ask(input logic [3:0] c, logic [31:0] d, e);
    cmd(c, 1'b0, d);
    chk("resp_valid", rv, 1);
    chk("resp_data", rd, e);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ticks beyond the count must be ignored, so two extra are sent
  task automatic burst(input int n, p, s, b);
    int k, p0 = n_pulse, s0 = n_second, b0 = n_bit;
    @(posedge clk_sys);
    arm <= 1'b1;
    @(posedge clk_sys);
    arm <= 1'b0;
    repeat (n + 2) begin
      @(posedge clk_sys);
      period_tick <= 1'b1;
    end
    @(posedge clk_sys);
    period_tick <= 1'b0;
    for (k = 0; k < 20 && burst_busy !== 1'b0; k++) @(posedge clk_sys);
    if (k == 20) begin
      num_errors++;
      tally_and_finish();
    end
    repeat (2) @(posedge clk_sys);
    chk("pulses", n_pulse - p0, p);
    chk("seconds", n_second - s0, s);
    chk("bits", n_bit - b0, b);
    $display("burst of %0d done", n);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk("hi", level_high_bus, 32'h01F401F4);
    chk("lo", level_low_bus, 32'hFE0CFE0C);
    chk("lim", level_limit_switch, 1'b0);
    chk("chk", error_check_switch, 1'b1);
    chk("cnt", period_count_per_arm, 17'h00001);
    ask(4'hA, 0, 0);
    ask(4'hB, 0, 32'h00004DD0);
    $display("reset test done");
    cmd(4'h6, 1'b1, 1);
    chk("lim", level_limit_switch, 1'b1);
    cmd(4'h0, 0, 32'h258);
    chk("hi", level_high_bus, 32'h01F401F4);
    cmd(4'h1, 1, 32'hFDA8);
    chk("lo", level_low_bus, 32'hFE0CFE0C);
    cmd(4'h2, 0, 32'h4B0);
    chk("hi", level_high_bus, 32'h01F401F4);
    cmd(4'h2, 0, 32'h320);
    chk("hi", level_high_bus, 32'h01F40190);
    chk("lo", level_low_bus, 32'hFE0CFE70);
    cmd(4'h3, 0, 32'h64);
    chk("hi", level_high_bus, 32'h01F401F4);
    chk("lo", level_low_bus, 32'hFE0CFED4);
    repeat (3) ask(4'hA, 0, 32'hFFFFFF23);
    ask(4'hA, 0, 0);
    cmd(4'h8, 0, 1);
    chk("on", output_enabled, 2'b01);
    cmd(4'h4, 0, 32'h190);
    cmd(4'h5, 0, 32'hFF00);
    chk("resp_data", rd, 0);
    repeat (2) ask(4'hA, 0, 32'hFFFFFF23);
    cmd(4'h0, 0, 32'h1C2);
    chk("hi", level_high_bus, 32'h01F401C2);
    cmd(4'h4, 1, 32'h190);
    cmd(4'h0, 1, 32'h1C2);
    chk("hi", level_high_bus, 32'h01F401C2);
    ask(4'hA, 0, 32'hFFFFFF23);
    cmd(4'h6, 0, 0);
    cmd(4'h0, 1, 32'h258);
    chk("hi", level_high_bus, 32'h025801C2);
    $display("limit test done");
    @(posedge clk_sys);
    panel_check_off <= 1'b1;
    @(posedge clk_sys);
    panel_check_off <= 1'b0;
    #1;
    chk("chk", error_check_switch, 1'b0);
    cmd(4'hC, 0, 0);
    ask(4'hA, 0, 0);
    cmd(4'h7, 0, 1);
    chk("chk", error_check_switch, 1'b1);
    repeat (QD + 1) cmd(4'hC, 0, 0);
    repeat (QD - 1) ask(4'hA, 0, 32'hFFFFFF22);
    ask(4'hA, 0, 32'hFFFFFEA2);
    ask(4'hA, 0, 0);
    $display("queue test done");
    @(posedge clk_sys);
    operation_condition <= 16'h0001;
    questionable_condition <= 16'h0002;
    cmd(4'hF, 0, 32'h000804D2);
    ask(4'hF, 0, 32'h000004D2);
    ask(4'hF, 32'h60000, 32'h1);
    cmd(4'hC, 0, 0);
    cmd(4'h9, 0, 0);
    for (i = 0; i < 8; i++) ask(4'hF, i << 16, stat_exp[i]);
    ask(4'hA, 0, 0);
    $display("preset test done");
    burst(1, 1, 0, 0);
    cmd(4'hC, 0, 2);
    cmd(4'hE, 0, 1);
    burst(2, 2, 2, 0);
    cmd(4'hE, 0, 0);
    cmd(4'hC, 0, 32'h10000);
    chk("cnt", period_count_per_arm, 17'h10000);
    cmd(4'hD, 0, 1);
    chk("patt", bit_pattern_operation, 0);
    cmd(4'hC, 0, 3);
    cmd(4'hD, 0, 1);
    burst(3, 0, 0, 3);
    chk("idx", bit_index, 3);
    cmd(4'hC, 0, 32'h4001);
    chk("cnt", period_count_per_arm, 17'h00003);
    cmd(4'hC, 0, 32'h4000);
    chk("cnt", period_count_per_arm, 17'h04000);
    tally_and_finish();
  end
endmodule // level_limit_error_queue_burst_test
`default_nettype wire

// *** sim/llq_checker.sv ***
// Purpose: port assertions of the command block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the top module below
`timescale 1ns/100ps
`default_nettype none
module llq_checker (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic [31:0] cmd_data,
  input wire logic        resp_valid,
  input wire logic [31:0] resp_data,
  input wire logic        arm,
  input wire logic        period_tick,
  input wire logic        level_limit_switch,
  input wire logic        bit_pattern_operation,
  input wire logic [16:0] period_count_per_arm,
  input wire logic        burst_busy,
  input wire logic        period_strobe,
  input wire logic        pulse_strobe,
  input wire logic        second_pulse_strobe,
  input wire logic        bit_strobe
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_err_answer;
    cmd_valid && cmd_code == 4'hA |=> resp_valid;
  endproperty
  a_err_answer: assert property (p_err_answer) else $error("no error answer");
  property p_version;
    cmd_valid && cmd_code == 4'hB |=> resp_valid && resp_data == 32'h00004DD0;
  endproperty
  a_version: assert property (p_version) else $error("bad version answer");
  property p_after_reset;
    $rose(reset_n) |-> period_count_per_arm == 17'h00001 && !level_limit_switch;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("bad reset state");
  property p_switch;
    cmd_valid && cmd_code == 4'h6 |=> level_limit_switch == $past(cmd_data[0]);
  endproperty
  a_switch: assert property (p_switch) else $error("limit switch not taken");
  property p_patt_range;
    cmd_valid && cmd_code == 4'hC && bit_pattern_operation
      && (cmd_data[16:0] < 17'h00002 || cmd_data[16:0] > 17'h04000) |=> $stable(period_count_per_arm);
  endproperty
  a_patt_range: assert property (p_patt_range) else $error("pattern count accepted");
  property p_arm;
    arm && !burst_busy |=> burst_busy;
  endproperty
  a_arm: assert property (p_arm) else $error("arm did not start");
  property p_tick;
    burst_busy && period_tick |=> period_strobe && (pulse_strobe || bit_strobe);
  endproperty
  a_tick: assert property (p_tick) else $error("tick lost");
  property p_double;
    second_pulse_strobe |-> pulse_strobe && !bit_strobe;
  endproperty
  a_double: assert property (p_double) else $error("stray second pulse");
endmodule // llq_checker
bind level_limit_error_queue_burst llq_checker i_llq_checker (
  .clk_sys, .reset_n, .cmd_valid, .cmd_code, .cmd_data, .resp_valid, .resp_data, .arm,
  .period_tick, .level_limit_switch, .bit_pattern_operation, .period_count_per_arm,
  .burst_busy, .period_strobe, .pulse_strobe, .second_pulse_strobe, .bit_strobe);
`default_nettype wire

// *** src/error_code_queue.v ***
// Purpose: first-in first-out store of error codes
// Assumes: push, pop and clear are one-cycle pulses
// Notes:   on overflow the newest entry is replaced by the overflow code
`timescale 1ns/100ps
`include "level_limit_map.vh"
`default_nettype none
module error_code_queue #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        clear,
  input  wire        push,
  input  wire [15:0] push_code,
  input  wire        pop,
  output wire [15:0] head_code,
  output wire        empty
);
  reg [15:0]   mem [0:DEPTH-1];
  reg [AW-1:0] rd_ptr;
  reg [AW-1:0] wr_ptr;
  reg [AW:0]   fill;
  wire         full = (fill == DEPTH[AW:0]);
  wire         do_pop = pop && !empty;

  assign empty     = (fill == {(AW+1){1'b0}});
  assign head_code = empty ? `ERR_NONE : mem[rd_ptr];

  always @(posedge clk_sys) begin
    if (!reset_n || clear) begin
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else begin
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && full && !do_pop) begin
        mem[wr_ptr - 1'b1] <= `ERR_OVERFLOW;
      end else if (push) begin
        mem[wr_ptr] <= push_code;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (push && !full && !do_pop) begin
        fill <= fill + 1'b1;
      end else if (do_pop && !(push)) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule // error_code_queue
`default_nettype wire

// *** src/level_limit_error_queue_burst.v ***
// Purpose: command side of a two-output pulse/pattern generator
// Assumes: host commands arrive pre-parsed as code, channel and data
// Notes:   levels and limits in signed millivolts
//
// What this block does
// - refuse high level above high limit
// - refuse low level below low limit
// - check also amplitude/offset; limits reset off
// - one limit switch for voltage and current
// - output on: refuse limit violated by level
// - preset clears event registers and error queue
// - preset: enables, falling zero, rising 7FFF
// - checking on by command/reset, panel only off
// - error queue first-in first-out, query pops
// - empty queue query returns zero
// - overflow replaces newest with -350
// - version query returns 1992.0
// - period count per arm, default one
// - count one, no pattern: one period
// - no pattern: counts 1 to 65536 burst
// - pattern: counts 2 to 16384 bits
// - no pattern: single or double pulse
// - amplitude high minus low, offset mean
`timescale 1ns/100ps
`include "level_limit_map.vh"
`default_nettype none
module level_limit_error_queue_burst #(
  parameter QUEUE_DEPTH = 8,
  parameter QUEUE_AW    = 3
) (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_code,
  input  wire        cmd_chan,
  input  wire [31:0] cmd_data,
  output reg         resp_valid,
  output reg  [31:0] resp_data,
  input  wire        panel_check_off,
  input  wire [15:0] operation_condition,
  input  wire [15:0] questionable_condition,
  input  wire        arm,
  input  wire        period_tick,
  output wire [31:0] level_high_bus,
  output wire [31:0] level_low_bus,
  output wire [1:0]  output_enabled,
  output reg         level_limit_switch,
  output reg         error_check_switch,
  output reg         bit_pattern_operation,
  output reg         double_pulse_select,
  output reg  [16:0] period_count_per_arm,
  output wire        burst_busy,
  output wire        period_strobe,
  output wire        pulse_strobe,
  output wire        second_pulse_strobe,
  output wire        bit_strobe,
  output wire [13:0] bit_index
);
  // ----
  // state
  // ----
  reg signed [15:0] level_high [0:1];
  reg signed [15:0] level_low  [0:1];
  reg signed [15:0] high_limit [0:1];
  reg signed [15:0] low_limit  [0:1];
  reg        [1:0]  output_on;
  reg        [15:0] operation_event_enable;
  reg        [15:0] operation_rising_filter;
  reg        [15:0] operation_falling_filter;
  reg        [15:0] questionable_event_enable;
  reg        [15:0] questionable_rising_filter;
  reg        [15:0] questionable_falling_filter;
  reg        [15:0] operation_event;
  reg        [15:0] questionable_event;
  reg        [15:0] operation_prev;
  reg        [15:0] questionable_prev;

  // ----
  // helpers
  // ----
  function signed [15:0] half_of;
    input signed [16:0] value;
    begin
      half_of = value[16:1];
    end
  endfunction

  function levels_ok;
    input        enabled;
    input signed [15:0] high, low, hlim, llim;
    begin
      levels_ok = !enabled || ((high <= hlim) && (low >= llim));
    end
  endfunction

  // ----
  // candidate levels for the addressed output
  // ----
  wire signed [15:0] cur_high  = level_high[cmd_chan];
  wire signed [15:0] cur_low   = level_low[cmd_chan];
  wire signed [15:0] cur_hlim  = high_limit[cmd_chan];
  wire signed [15:0] cur_llim  = low_limit[cmd_chan];
  wire signed [15:0] arg       = cmd_data[15:0];
  wire signed [16:0] level_sum = {cur_high[15], cur_high} + {cur_low[15], cur_low};
  wire signed [16:0] level_dif = {cur_high[15], cur_high} - {cur_low[15], cur_low};
  wire signed [16:0] arg_x2    = {arg, 1'b0};
  reg  signed [15:0] next_high;
  reg  signed [15:0] next_low;

  always @* begin
    next_high = cur_high;
    next_low  = cur_low;
    case (cmd_code)
      `CMD_SET_HIGH: begin
        next_high = arg;
      end
      `CMD_SET_LOW: begin
        next_low = arg;
      end
      `CMD_SET_AMPL: begin
        next_high = half_of(level_sum + {arg[15], arg});
        next_low  = half_of(level_sum - {arg[15], arg});
      end
      `CMD_SET_OFFS: begin
        next_high = half_of(arg_x2 + level_dif);
        next_low  = half_of(arg_x2 - level_dif);
      end
      default: begin
        next_high = cur_high;
      end
    endcase
  end

  wire is_level_cmd = (cmd_code == `CMD_SET_HIGH) || (cmd_code == `CMD_SET_LOW) ||
                      (cmd_code == `CMD_SET_AMPL) || (cmd_code == `CMD_SET_OFFS);
  // one check covers high/low and amplitude/offset forms
  wire level_refused = is_level_cmd &&
                       !levels_ok(level_limit_switch, next_high, next_low, cur_hlim, cur_llim);
  // with the output live, a new high limit may not cut below, nor a new low limit above, the level in use
  wire hlim_refused  = output_on[cmd_chan] && (arg < cur_high);
  wire llim_refused  = output_on[cmd_chan] && (arg > cur_low);
  wire [16:0] count_arg = cmd_data[16:0];
  wire count_refused = bit_pattern_operation ?
                       ((count_arg < `COUNT_MIN_BURST) || (count_arg > `COUNT_MAX_PATT)) :
                       ((count_arg < `COUNT_DEFAULT) || (count_arg > `COUNT_MAX_PULSE));
  // switching pattern on is refused unless the present count is legal there
  wire patt_refused  = cmd_data[0] && ((period_count_per_arm < `COUNT_MIN_BURST) ||
                       (period_count_per_arm > `COUNT_MAX_PATT));

  // ----
  // error queue
  // ----
  reg         err_push;
  reg  [15:0] err_code;
  wire        err_pop = cmd_valid && (cmd_code == `CMD_ERR_QUERY);
  wire        preset  = cmd_valid && (cmd_code == `CMD_STAT_PRESET);
  wire [15:0] err_head;

  always @* begin
    err_push = 1'b0;
    err_code = `ERR_SETTINGS;
    if (cmd_valid && error_check_switch) begin
      case (cmd_code)
        `CMD_SET_HIGH, `CMD_SET_LOW, `CMD_SET_AMPL, `CMD_SET_OFFS: begin
          err_push = level_refused;
        end
        `CMD_SET_HLIM: begin
          err_push = hlim_refused;
        end
        `CMD_SET_LLIM: begin
          err_push = llim_refused;
        end
        `CMD_SET_COUNT: begin
          err_push = count_refused;
          err_code = `ERR_OUT_OF_RANGE;
        end
        `CMD_PATT_SWITCH: begin
          err_push = patt_refused;
        end
        default: begin
          err_push = 1'b0;
        end
      endcase
    end
  end

  error_code_queue #(
    .DEPTH (QUEUE_DEPTH),
    .AW    (QUEUE_AW)
  ) u_error_queue (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clear     (preset),
    .push      (err_push),
    .push_code (err_code),
    .pop       (err_pop),
    .head_code (err_head),
    .empty     ()
  );

  // ----
  // command execution
  // ----
  wire [2:0] stat_sel = cmd_data[`STAT_SEL_HI:`STAT_SEL_LO];
  wire       stat_wr  = cmd_valid && (cmd_code == `CMD_STAT_ACCESS) && cmd_data[`STAT_WRITE_BIT];
  wire       stat_rd  = cmd_valid && (cmd_code == `CMD_STAT_ACCESS) && !cmd_data[`STAT_WRITE_BIT];
  reg [15:0] stat_value;

  always @* begin
    case (stat_sel)
      3'h0:    stat_value = operation_event_enable;
      3'h1:    stat_value = operation_rising_filter;
      3'h2:    stat_value = operation_falling_filter;
      3'h3:    stat_value = questionable_event_enable;
      3'h4:    stat_value = questionable_rising_filter;
      3'h5:    stat_value = questionable_falling_filter;
      3'h6:    stat_value = operation_event;
      default: stat_value = questionable_event;
    endcase
  end

  integer i;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      for (i = 0; i < 2; i = i + 1) begin
        level_high[i] <= `HIGH_DEFAULT;
        level_low[i]  <= `LOW_DEFAULT;
        high_limit[i] <= `HLIM_DEFAULT;
        low_limit[i]  <= `LLIM_DEFAULT;
      end
      output_on             <= 2'h0;
      level_limit_switch    <= 1'b0;
      error_check_switch    <= 1'b1;
      bit_pattern_operation <= 1'b0;
      double_pulse_select   <= 1'b0;
      period_count_per_arm  <= `COUNT_DEFAULT;
    end else if (cmd_valid) begin
      case (cmd_code)
        `CMD_SET_HIGH, `CMD_SET_LOW, `CMD_SET_AMPL, `CMD_SET_OFFS: begin
          if (!level_refused) begin
            level_high[cmd_chan] <= next_high;
            level_low[cmd_chan]  <= next_low;
          end
        end
        `CMD_SET_HLIM: begin
          if (!hlim_refused) begin
            high_limit[cmd_chan] <= arg;
          end
        end
        `CMD_SET_LLIM: begin
          if (!llim_refused) begin
            low_limit[cmd_chan] <= arg;
          end
        end
        `CMD_LIMIT_SWITCH: begin
          level_limit_switch <= cmd_data[0];
        end
        `CMD_CHECK_SWITCH: begin
          error_check_switch <= cmd_data[0];
        end
        `CMD_OUTPUT_SWITCH: begin
          output_on[cmd_chan] <= cmd_data[0];
        end
        `CMD_SET_COUNT: begin
          if (!count_refused) begin
            period_count_per_arm <= count_arg;
          end
        end
        `CMD_PATT_SWITCH: begin
          if (!patt_refused) begin
            bit_pattern_operation <= cmd_data[0];
          end
        end
        `CMD_DOUBLE_SWITCH: begin
          double_pulse_select <= cmd_data[0];
        end
        default: begin
          output_on <= output_on;
        end
      endcase
    end else if (panel_check_off) begin
      error_check_switch <= 1'b0;
    end
  end

  // ----
  // status groups
  // ----
  wire [15:0] oper_hits = (operation_condition & ~operation_prev & operation_rising_filter) |
                          (~operation_condition & operation_prev & operation_falling_filter);
  wire [15:0] ques_hits = (questionable_condition & ~questionable_prev & questionable_rising_filter) |
                          (~questionable_condition & questionable_prev & questionable_falling_filter);
  wire        oper_clr  = preset || (stat_rd && (stat_sel == 3'h6));
  wire        ques_clr  = preset || (stat_rd && (stat_sel == 3'h7));

  always @(posedge clk_sys) begin
    if (!reset_n || preset) begin
      operation_event_enable      <= `ENABLE_PRESET;
      operation_rising_filter     <= `RISING_PRESET;
      operation_falling_filter    <= `FALLING_PRESET;
      questionable_event_enable   <= `ENABLE_PRESET;
      questionable_rising_filter  <= `RISING_PRESET;
      questionable_falling_filter <= `FALLING_PRESET;
    end else if (stat_wr) begin
      case (stat_sel)
        3'h0:    operation_event_enable      <= cmd_data[15:0];
        3'h1:    operation_rising_filter     <= cmd_data[15:0];
        3'h2:    operation_falling_filter    <= cmd_data[15:0];
        3'h3:    questionable_event_enable   <= cmd_data[15:0];
        3'h4:    questionable_rising_filter  <= cmd_data[15:0];
        3'h5:    questionable_falling_filter <= cmd_data[15:0];
        default: operation_event_enable      <= operation_event_enable;
      endcase
    end
  end

  // new hits win over a clear in the same cycle
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      operation_event    <= 16'h0000;
      questionable_event <= 16'h0000;
      operation_prev     <= 16'h0000;
      questionable_prev  <= 16'h0000;
    end else begin
      operation_prev     <= operation_condition;
      questionable_prev  <= questionable_condition;
      operation_event    <= (oper_clr ? 16'h0000 : operation_event) | oper_hits;
      questionable_event <= (ques_clr ? 16'h0000 : questionable_event) | ques_hits;
    end
  end

  // ----
  // answers
  // ----
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      resp_valid <= 1'b0;
      resp_data  <= 32'h00000000;
    end else begin
      resp_valid <= cmd_valid && (err_pop || stat_rd || (cmd_code == `CMD_VERS_QUERY));
      if (err_pop) begin
        resp_data <= {{16{err_head[15]}}, err_head};
      end else if (cmd_valid && (cmd_code == `CMD_VERS_QUERY)) begin
        resp_data <= {16'h0000, `VERSION_X10};
      end else if (stat_rd) begin
        resp_data <= {16'h0000, stat_value};
      end
    end
  end

  // ----
  // period sequencer and level outputs
  // ----
  period_sequencer #(
    .CW (17),
    .BW (14)
  ) u_sequencer (
    .clk_sys             (clk_sys),
    .reset_n             (reset_n),
    .arm                 (arm),
    .period_tick         (period_tick),
    .count               (period_count_per_arm),
    .pattern_on          (bit_pattern_operation),
    .double_on           (double_pulse_select),
    .busy                (burst_busy),
    .period_strobe       (period_strobe),
    .pulse_strobe        (pulse_strobe),
    .second_pulse_strobe (second_pulse_strobe),
    .bit_strobe          (bit_strobe),
    .bit_index           (bit_index)
  );

  assign level_high_bus = {level_high[1], level_high[0]};
  assign level_low_bus  = {level_low[1], level_low[0]};
  assign output_enabled = output_on;
endmodule // level_limit_error_queue_burst
`default_nettype wire

// *** src/level_limit_map.vh ***
// Purpose: shared command codes, defaults and limits of the control block
// Assumes: levels and limits are signed millivolts, 16 bits
// Notes:   definitions only
`ifndef LEVEL_LIMIT_MAP_VH
`define LEVEL_LIMIT_MAP_VH
// ----
// command codes
// ----
`define CMD_SET_HIGH      4'h0
`define CMD_SET_LOW       4'h1
`define CMD_SET_AMPL      4'h2
`define CMD_SET_OFFS      4'h3
`define CMD_SET_HLIM      4'h4
`define CMD_SET_LLIM      4'h5
`define CMD_LIMIT_SWITCH  4'h6
`define CMD_CHECK_SWITCH  4'h7
`define CMD_OUTPUT_SWITCH 4'h8
`define CMD_STAT_PRESET   4'h9
`define CMD_ERR_QUERY     4'hA
`define CMD_VERS_QUERY    4'hB
`define CMD_SET_COUNT     4'hC
`define CMD_PATT_SWITCH   4'hD
`define CMD_DOUBLE_SWITCH 4'hE
`define CMD_STAT_ACCESS   4'hF
// ----
// defaults and fixed values
// ----
`define HIGH_DEFAULT      16'h01F4
`define LOW_DEFAULT       16'hFE0C
`define HLIM_DEFAULT      16'h01F4
`define LLIM_DEFAULT      16'hFE0C
`define COUNT_DEFAULT     17'h00001
`define COUNT_MIN_BURST   17'h00002
`define COUNT_MAX_PULSE   17'h10000
`define COUNT_MAX_PATT    17'h04000
`define ENABLE_PRESET     16'h0000
`define RISING_PRESET     16'h7FFF
`define FALLING_PRESET    16'h0000
`define VERSION_X10       16'h4DD0
`define ERR_NONE          16'h0000
`define ERR_OVERFLOW      16'hFEA2
`define ERR_OUT_OF_RANGE  16'hFF22
`define ERR_SETTINGS      16'hFF23
// ----
// status access field layout in cmd_data
// ----
`define STAT_WRITE_BIT    19
`define STAT_SEL_HI       18
`define STAT_SEL_LO       16
`endif

// *** src/period_sequencer.v ***
// Purpose: counts pulse or bit periods after each arming event
// Assumes: period_tick marks each period trigger, one cycle wide
// Notes:   count is latched at arming; arming while busy is ignored
`timescale 1ns/100ps
`default_nettype none
module period_sequencer #(
  parameter CW = 17,
  parameter BW = 14
) (
  input  wire          clk_sys,
  input  wire          reset_n,
  input  wire          arm,
  input  wire          period_tick,
  input  wire [CW-1:0] count,
  input  wire          pattern_on,
  input  wire          double_on,
  output reg           busy,
  output reg           period_strobe,
  output reg           pulse_strobe,
  output reg           second_pulse_strobe,
  output reg           bit_strobe,
  output reg  [BW-1:0] bit_index
);
  reg [CW-1:0] remaining;
  reg          patt_latched;
  reg          double_latched;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      busy                <= 1'b0;
      remaining           <= {CW{1'b0}};
      patt_latched        <= 1'b0;
      double_latched      <= 1'b0;
      period_strobe       <= 1'b0;
      pulse_strobe        <= 1'b0;
      second_pulse_strobe <= 1'b0;
      bit_strobe          <= 1'b0;
      bit_index           <= {BW{1'b0}};
    end else begin
      period_strobe       <= 1'b0;
      pulse_strobe        <= 1'b0;
      second_pulse_strobe <= 1'b0;
      bit_strobe          <= 1'b0;
      if (!busy && arm) begin
        busy           <= 1'b1;
        remaining      <= count;
        patt_latched   <= pattern_on;
        double_latched <= double_on;
        bit_index      <= {BW{1'b0}};
      end else if (busy && period_tick) begin
        period_strobe <= 1'b1;
        if (patt_latched) begin
          bit_strobe <= 1'b1;
          bit_index  <= bit_index + 1'b1;
        end else begin
          pulse_strobe        <= 1'b1;
          second_pulse_strobe <= double_latched;
        end
        remaining <= remaining - 1'b1;
        if (remaining == {{(CW-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule // period_sequencer
`default_nettype wire
